// ---- vtp_cam_timer.sv ----
`timescale 1ns/1ns
// Per-camera shutter and strobe timer, counting microseconds from trigger.
module vtp_cam_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Timebase and start.
  input  wire logic         tick_i,
  input  wire logic         start_i,
  // Settings in microseconds.
  input  wire logic [W-1:0] tdly_i,
  input  wire logic [W-1:0] shut_i,
  input  wire logic [W-1:0] sdly_i,
  input  wire logic [W-1:0] swid_i,
  // Results.
  output logic              shutter_o,
  output logic              strobe_o,
  output logic              busy_o
);
  logic [W+1:0] t_ff;
  logic [W+1:0] shut_on;
  logic [W+1:0] shut_off;
  logic [W+1:0] stb_on;
  logic [W+1:0] stb_off;
  logic [W+1:0] t_end;

  // Window edges; the strobe delay is counted from trigger receipt.
  assign shut_on  = {2'b00, tdly_i};
  assign shut_off = shut_on + {2'b00, shut_i};
  assign stb_on   = {2'b00, sdly_i};
  assign stb_off  = stb_on + {2'b00, swid_i};
  assign t_end    = (shut_off > stb_off) ? shut_off : stb_off;

  // ****************************************************************
  // Timeline.
  // ****************************************************************
  // Retriggering while busy is ignored so a window is never cut short.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t_ff      <= '0;
      busy_o    <= 1'b0;
      shutter_o <= 1'b0;
      strobe_o  <= 1'b0;
    end else begin
      if (start_i && !busy_o) begin
        t_ff   <= '0;
        busy_o <= 1'b1;
      end else if (busy_o && tick_i) begin
        t_ff <= t_ff + 1'b1;
        if (t_ff + 1'b1 >= t_end) begin
          busy_o <= 1'b0;
        end
      end
      shutter_o <= busy_o && (t_ff >= shut_on) && (t_ff < shut_off);
      strobe_o  <= busy_o && (t_ff >= stb_on) && (t_ff < stb_off);
    end
  end
endmodule // vtp_cam_timer

// ---- vtp_host_model.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Host controller and strobe device seen from the sequencer pins.
// ****************************************************************
module vtp_host_model (
  // Clock.
  input  wire logic        clk_i,
  // Bench requests: kind 0 holds the trigger, kind 1 the host reset.
  input  wire logic        go_i,
  input  wire logic        kind_i,
  input  wire logic [31:0] len_i,
  // Host pins.
  output logic             measure_trigger_input_o,
  output logic             hrst_o,
  // Strobe device side.
  input  wire logic        pol_i,
  input  wire logic [1:0]  strobe_i,
  output logic [31:0]      fires_o
);
  logic [31:0] cnt_ff = 32'h0000_0000;
  logic        kind_ff = 1'b0;
  logic [1:0]  act_ff = 2'b00;
  logic [1:0]  act;
  logic [31:0] fires_ff = 32'h0000_0000;
  assign fires_o = fires_ff;
  // A pin is held exactly as long as asked, so short holds can be refused.
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_ff <= len_i;
      kind_ff <= kind_i;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  assign measure_trigger_input_o = !kind_ff && cnt_ff != 0;
  assign hrst_o = kind_ff && cnt_ff != 0;
  // The lamp fires on each move to the active level, which the polarity picks.
  assign act = strobe_i ^ {2{pol_i}};
  always @(posedge clk_i) begin
    act_ff <= act;
    fires_ff <= fires_ff + 32'(act[0] & ~act_ff[0]) + 32'(act[1] & ~act_ff[1]);
  end
endmodule // vtp_host_model

// ---- vtp_io_seq.sv ----
`timescale 1ns/1ns
// Functional notes
// - Ready turns off within 0.5 ms of a taken trigger.
// - Measurement interval: image, image plus measure, or plus display.
// - Each camera opens its shutter after its own delay, up to 65.535 ms.
// - Each camera's shutter window follows its setting, capped at 2 ms.
// - Each camera fires the strobe after its own delay, up to 65.535 ms.
// - Strobe stays active for its per-camera width, then returns inactive.
// - Strobe active polarity is selectable.
// - Two cameras stagger shutter windows by their own trigger delays.
// - Ready offers three selectable timing patterns.
// - Level mode holds the judgment until the next judgment.
// - One-shot mode holds judgment on for output time, then off.
// - Run status asserts only after startup processing completes.
// - After run, initialise; then ready on and commands accepted.
// - Accepting a command drops ready for the whole command.
// - Ready changes again only after result output has finished.
// - Overall judgment fails if any used term fails, otherwise passes.
module vtp_io_seq
  import vtp_pkg::*;
#(
  parameter int unsigned        NCAM        = vtp_pkg::NUM_CAM,
  parameter int unsigned        TERMS       = 8,
  parameter int unsigned        MEASURE_TRIGGER_INPUT_MIN    = vtp_pkg::MEASURE_TRIGGER_INPUT_MIN_CYC,
  parameter int unsigned        RST_MIN     = vtp_pkg::RESET_MIN_CYC
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Host pins.
  input  wire logic             measure_trigger_input_i,
  input  wire logic             host_reset_i,
  // Register port.
  input  wire logic [5:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // Outputs to host and strobe device.
  output logic                  ready_o,
  output logic                  judge_o,
  output logic                  run_o,
  output logic      [NCAM-1:0]  shutter_o,
  output logic      [NCAM-1:0]  strobe_fire_output_o
);
  import vtp_pkg::*;

  typedef enum logic [5:0] {
    VTP_BOOT = 6'b000001,
    VTP_INIT = 6'b000010,
    VTP_IDLE = 6'b000100,
    VTP_MEAS = 6'b001000,
    VTP_CMD  = 6'b010000,
    VTP_OUT  = 6'b100000
  } vtp_state_t;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  vtp_state_t              state_ff;
  vtp_state_t              nxt_state;
  logic [31:0]             ctrl_ff;
  logic [TERMS-1:0]        terms_ff;
  logic [TERMS-1:0]        used_ff;
  logic [15:0]             or_time_ff;
  logic [15:0]             or_cnt_ff;
  logic [DLY_W-1:0]        cfg_ff [NCAM][4];
  logic [31:0]             measure_trigger_input_cnt_ff;
  logic [31:0]             rst_cnt_ff;
  logic                    measure_trigger_input_taken;
  logic                    host_rst_ff;
  logic                    phase_ff;
  logic                    tick;
  logic [NCAM-1:0]         busy;
  logic [NCAM-1:0]         shut_raw;
  logic [NCAM-1:0]         stb_raw;
  logic                    judge_fail;
  logic                    meas_ev;
  logic [1:0]              ena_mode;
  logic [5:0]              cam_off;
  logic [2:0]              cam_sel;

  assign ena_mode = ctrl_ff[CTRL_ENA_MODE_LO +: 2];
  assign cam_off  = addr_i - REG_CAM_BASE;
  // The full camera index is kept so slots past the last camera are refused.
  assign cam_sel  = {1'b0, cam_off[5:4]};

  // ****************************************************************
  // Trigger qualification and host reset.
  // ****************************************************************
  // A trigger counts once it has been held for the minimum; shorter blips are ignored.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      measure_trigger_input_cnt_ff <= 32'h0000_0000;
    end else if (!measure_trigger_input_i) begin
      measure_trigger_input_cnt_ff <= 32'h0000_0000;
    end else if (measure_trigger_input_cnt_ff < MEASURE_TRIGGER_INPUT_MIN) begin
      measure_trigger_input_cnt_ff <= measure_trigger_input_cnt_ff + 32'h0000_0001;
    end
  end
  assign measure_trigger_input_taken = (measure_trigger_input_cnt_ff == MEASURE_TRIGGER_INPUT_MIN - 1) && measure_trigger_input_i;

  // Host reset is accepted only after the full hold time.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_cnt_ff  <= 32'h0000_0000;
      host_rst_ff <= 1'b0;
    end else begin
      rst_cnt_ff  <= host_reset_i ? ((rst_cnt_ff < RST_MIN) ? rst_cnt_ff + 32'h0000_0001
                                                           : rst_cnt_ff) : 32'h0000_0000;
      host_rst_ff <= host_reset_i && (rst_cnt_ff == RST_MIN - 1);
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Init, command, measure, display and output done and command accept self-clear; boot done holds until host reset or a control register write.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff    <= CTRL_RESET;
      terms_ff   <= '0;
      used_ff    <= '0;
      or_time_ff <= 16'h0000;
    end else begin
      ctrl_ff[CTRL_CMD_ACCEPT:CTRL_INIT_DONE] <= '0;
      ctrl_ff[CTRL_BOOT_DONE] <= ctrl_ff[CTRL_BOOT_DONE] && !host_rst_ff;
      if (wr_i) begin
        unique case (addr_i)
          REG_CTRL:    ctrl_ff    <= wdata_i;
          REG_JUDGE:   {used_ff, terms_ff} <= {wdata_i[16 +: TERMS], wdata_i[0 +: TERMS]};
          REG_OR_TIME: or_time_ff <= wdata_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // Per-camera settings; shutter time is clamped to its ceiling.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ff <= '{default: '{default: '0}};
    end else if (wr_i && addr_i >= REG_CAM_BASE && cam_sel < NCAM) begin
      cfg_ff[cam_sel[0]][cam_off[3:2]] <= (cam_off[3:0] == CAM_SHUT[3:0] &&
          wdata_i[15:0] > 16'(SHUT_MAX_US)) ? 16'(SHUT_MAX_US) : wdata_i[15:0];
    end
  end

  // ****************************************************************
  // Register reads.
  // ****************************************************************
  // Read data stand in the cycle after the strobe only; unmapped reads return zero.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (!rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      unique case (addr_i)
        REG_CTRL:    rdata_o <= ctrl_ff & 32'h0000_000F;
        REG_STATUS:  rdata_o <= {20'h0_0000, busy[0], busy[NCAM-1], state_ff, judge_o,
                                 ready_o, run_o, judge_fail};
        REG_JUDGE:   rdata_o <= {8'h00, 8'(used_ff), 8'h00, 8'(terms_ff)};
        REG_OR_TIME: rdata_o <= {16'h0000, or_time_ff};
        default: begin
          if (addr_i >= REG_CAM_BASE && cam_sel < NCAM) begin
            rdata_o <= {16'h0000, cfg_ff[cam_sel[0]][cam_off[3:2]]};
          end else begin
            rdata_o <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Run sequencer.
  // ****************************************************************
  // Next-state logic; the ready pattern picks which done event ends a measurement.
  always_comb begin
    meas_ev = 1'b0;
    unique case (ena_mode)
      VTP_ENA_IMAGE: meas_ev = !(|busy);
      VTP_ENA_MEAS:  meas_ev = ctrl_ff[CTRL_MEAS_DONE];
      default:       meas_ev = ctrl_ff[CTRL_DISP_DONE];
    endcase
    nxt_state = state_ff;
    unique case (state_ff)
      VTP_BOOT: if (ctrl_ff[CTRL_BOOT_DONE]) nxt_state = VTP_INIT;
      VTP_INIT: if (ctrl_ff[CTRL_INIT_DONE]) nxt_state = VTP_IDLE;
      VTP_IDLE: begin
        if (measure_trigger_input_taken) nxt_state = VTP_MEAS;
        else if (ctrl_ff[CTRL_CMD_ACCEPT]) nxt_state = VTP_CMD;
      end
      VTP_MEAS: if (phase_ff && meas_ev) nxt_state = VTP_OUT;
      VTP_CMD:  if (ctrl_ff[CTRL_CMD_DONE]) nxt_state = VTP_OUT;
      VTP_OUT:  if (ctrl_ff[CTRL_OUT_DONE]) nxt_state = VTP_IDLE;
      default:  nxt_state = VTP_BOOT;
    endcase
    if (host_rst_ff) nxt_state = VTP_BOOT;
  end

  // State register and a one-cycle guard so camera busy is seen after start.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= VTP_BOOT;
      phase_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= (state_ff == VTP_MEAS);
    end
  end

  // Run and ready levels; ready drops the cycle after a trigger, well inside the limit.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_o   <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      run_o   <= (nxt_state != VTP_BOOT);
      ready_o <= (nxt_state == VTP_IDLE);
    end
  end

  // ****************************************************************
  // Judgment output.
  // ****************************************************************
  assign judge_fail = |(terms_ff & used_ff);

  // Judgment is published when the measurement ends.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      judge_o   <= 1'b0;
      or_cnt_ff <= 16'h0000;
    end else if (state_ff == VTP_MEAS && nxt_state == VTP_OUT) begin
      judge_o   <= judge_fail;
      or_cnt_ff <= or_time_ff;
    end else if (ctrl_ff[CTRL_OR_ONESHOT] && judge_o) begin
      if (or_cnt_ff == 16'h0000) begin
        judge_o <= 1'b0;
      end else if (tick) begin
        or_cnt_ff <= or_cnt_ff - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Cameras.
  // ****************************************************************
  vtp_us_tick #(
    .DIV      (US_CYCLES)
  ) u_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_o   (tick)
  );

  for (genvar c = 0; c < NCAM; c++) begin : g_cam
    vtp_cam_timer #(
      .W         (DLY_W)
    ) u_cam (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .tick_i    (tick),
      .start_i   (measure_trigger_input_taken && state_ff == VTP_IDLE),
      .tdly_i    (cfg_ff[c][0]),
      .shut_i    (cfg_ff[c][1]),
      .sdly_i    (cfg_ff[c][2]),
      .swid_i    (cfg_ff[c][3]),
      .shutter_o (shut_raw[c]),
      .strobe_o  (stb_raw[c]),
      .busy_o    (busy[c])
    );
  end

  // Polarity is applied after the timer so the firing level is a register.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shutter_o            <= '0;
      strobe_fire_output_o <= '0;
    end else begin
      shutter_o            <= shut_raw;
      strobe_fire_output_o <= stb_raw ^ {NCAM{ctrl_ff[CTRL_STB_POL]}};
    end
  end

endmodule // vtp_io_seq

// ---- vtp_io_seq_sva.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Port checker for the I/O sequencer.
// ****************************************************************
module vtp_io_seq_sva
  import vtp_pkg::*;
#(
  parameter int unsigned NCAM = 2
) (
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  // Host pins and register port.
  input  wire logic            measure_trigger_input_i,
  input  wire logic            host_reset_i,
  input  wire logic [5:0]      addr_i,
  input  wire logic [31:0]     wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  input  wire logic [31:0]     rdata_o,
  // Outputs.
  input  wire logic            ready_o,
  input  wire logic            judge_o,
  input  wire logic            run_o,
  input  wire logic [NCAM-1:0] shutter_o,
  input  wire logic [NCAM-1:0] strobe_fire_output_o
);
  localparam int SHUT_LIM = 200100;
  int shut_cnt_ff;
  // Camera 0 window length in cycles; a stuck window would grow past the cap.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shut_cnt_ff <= 0;
    end else begin
      shut_cnt_ff <= shutter_o[0] ? shut_cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rd_answer_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data seen outside the read answer cycle");
  measure_trigger_input_taken_a: assert property ($rose(measure_trigger_input_i) && ready_o && !wr_i
    ##1 measure_trigger_input_i [*4] |-> ##[0:3] !ready_o)
    else $error("ready did not drop after a full trigger");
  short_measure_trigger_input_a: assert property (ready_o && !wr_i && !host_reset_i
    ##1 $rose(measure_trigger_input_i) ##1 measure_trigger_input_i [*2]
    ##1 !measure_trigger_input_i |-> ##1 ready_o)
    else $error("short trigger was taken");
  ready_run_a: assert property (ready_o |-> run_o)
    else $error("ready high without run");
  run_rise_a: assert property ($rose(run_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("run rose without startup completion");
  run_fall_a: assert property ($fell(run_o) |-> $past(host_reset_i, 2))
    else $error("run fell without host reset");
  ready_rise_a: assert property ($rose(ready_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("ready rose without a completion write");
  judge_rise_a: assert property ($rose(judge_o) |-> !$past(ready_o))
    else $error("judgment rose while ready");
  shut_cap_a: assert property (shut_cnt_ff <= SHUT_LIM)
    else $error("shutter window over its cap");
  cover property ($fell(ready_o));
  cover property ($rose(judge_o));
  cover property ($rose(shutter_o[0]));
endmodule // vtp_io_seq_sva

bind vtp_io_seq vtp_io_seq_sva #(.NCAM(NCAM)) u_sva (.clk_i(clk_i), .resetn_i(resetn_i),
  .measure_trigger_input_i(measure_trigger_input_i), .host_reset_i(host_reset_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ready_o(ready_o), .judge_o(judge_o), .run_o(run_o), .shutter_o(shutter_o),
  .strobe_fire_output_o(strobe_fire_output_o));

// ---- vtp_io_seq_tb.sv ----
`timescale 1ns/1ns
module vtp_io_seq_tb;
  import vtp_pkg::*;
  // ****************************************************************
  // Stimulus, recorder and scoreboard.
  // ****************************************************************
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [5:0]  addr_i = 6'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        go = 1'b0;
  logic        kind = 1'b0;
  logic [31:0] len = 32'h0000_0000;
  logic        pol = 1'b0;
  logic [7:0]  seed = 8'h5E;
  logic [31:0] rdata_o, fires, st;
  logic        ready_o, judge_o, run_o, measure_trigger_input, hrst, rdy_q, jd_q;
  logic [1:0]  shutter_o, strobe_fire_output_o, sh_q, st_q, act;
  int          n_fail, checked, cyc, t_go, t_jr, t_jw;
  int          t_sh[2], t_sw[2], t_st[2], t_pw[2];
  int          tdly[2] = '{1, 5};
  int          shut[2] = '{2, 2};
  int          sdly[2] = '{3, 4};
  int          swid[2] = '{2, 1};

  vtp_io_seq #(.MEASURE_TRIGGER_INPUT_MIN(5), .RST_MIN(20)) DUT (.clk_i(clk_i), .resetn_i(resetn_i),
    .measure_trigger_input_i(measure_trigger_input), .host_reset_i(hrst), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ready_o(ready_o), .judge_o(judge_o),
    .run_o(run_o), .shutter_o(shutter_o), .strobe_fire_output_o(strobe_fire_output_o));
  vtp_host_model u_host (.clk_i(clk_i), .go_i(go), .kind_i(kind), .len_i(len), .measure_trigger_input_o(measure_trigger_input),
    .hrst_o(hrst), .pol_i(pol), .strobe_i(strobe_fire_output_o), .fires_o(fires));

  // Free-running clock.
  always #5 clk_i = ~clk_i;
  assign act = strobe_fire_output_o ^ {2{pol}};
  // Edge times in cycles, so delays are judged from the outputs alone.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rdy_q <= ready_o;
    jd_q <= judge_o;
    sh_q <= shutter_o;
    st_q <= act;
    if (rdy_q && !ready_o) t_go <= cyc;
    if (judge_o && !jd_q) t_jr <= cyc;
    if (!judge_o && jd_q) t_jw <= cyc - t_jr;
    for (int c = 0; c < 2; c++) begin
      if (shutter_o[c] && !sh_q[c]) t_sh[c] <= cyc;
      if (!shutter_o[c] && sh_q[c]) t_sw[c] <= cyc - t_sh[c];
      if (act[c] && !st_q[c]) t_st[c] <= cyc;
      if (!act[c] && st_q[c]) t_pw[c] <= cyc - t_st[c];
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Tick phase may shift an edge by up to one microsecond.
  task automatic near(input int x, input int us);
    check(32'(x > us * 100 - 110 && x < us * 100 + 110), 32'h1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask
  task automatic host(input logic k, input int n);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= k;
    len <= n;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (n + 2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    rd(REG_STATUS, st);
    while ((st & m) !== v && n < 3000) begin
      rd(REG_STATUS, st);
      n++;
    end
    check(32'(n < 3000), 32'h1);
  endtask
  // One measurement job in the given ready pattern.
  task automatic job(input int mode, input logic os);
    logic [7:0]  f, u;
    logic [31:0] cfg, f0;
    seed = lfsr(seed);
    f = os ? (seed | 8'h01) : seed;
    seed = lfsr(seed);
    u = os ? 8'hFF : seed;
    cfg = 32'(mode) | (32'(os) << 2) | (32'(pol) << 3);
    wr(REG_JUDGE, {8'h00, u, 8'h00, f});
    wr(REG_CTRL, cfg);
    settle();
    check(32'(strobe_fire_output_o), {30'h0, pol, pol});
    // A level judgment left high times out first, so the new one shows an edge.
    while (os && judge_o) @(negedge clk_i);
    f0 = fires;
    host(1'b0, 8);
    check(32'(ready_o), 32'h0);
    poll(32'h0000_0C00, 32'h0);
    if (mode > 0) begin
      check(32'(st[9]), 32'h0);
      wr(REG_CTRL, cfg | 32'h0000_0080);
      if (mode == 2) begin
        rd(REG_STATUS, st);
        check(32'(st[9]), 32'h0);
        wr(REG_CTRL, cfg | 32'h0000_0100);
      end
    end
    poll(32'h0000_0200, 32'h0000_0200);
    check(32'(judge_o), 32'((f & u) != 0));
    check(32'(ready_o), 32'h0);
    for (int c = 0; c < 2; c++) begin
      near(t_sh[c] - t_go, tdly[c]);
      near(t_sw[c], shut[c]);
      near(t_st[c] - t_go, sdly[c]);
      near(t_pw[c], swid[c]);
    end
    near(t_sh[1] - t_sh[0], tdly[1] - tdly[0]);
    check(fires - f0, 32'h2);
    if (os) begin
      for (int n = 0; n < 2000 && judge_o; n++) @(negedge clk_i);
      settle();
      near(t_jw, 3);
    end
    wr(REG_CTRL, cfg | 32'h0000_0200);
    settle();
    check(32'(ready_o), 32'h1);
    check(32'(judge_o), os ? 32'h0 : 32'((f & u) != 0));
    $display("test job mode %0d done", mode);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest expected run.
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end

  // Main sequence: reset, startup, refusals, command, jobs, host reset.
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(REG_CTRL, st);
    check(st, CTRL_RESET);
    rd(REG_STATUS, st);
    check(st, 32'h0000_0010);
    wr(6'h30, 32'h0000_FFFF);
    rd(6'h30, st);
    check(st, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0010);
    settle();
    check(32'(run_o), 32'h1);
    check(32'(ready_o), 32'h0);
    wr(REG_CTRL, 32'h0000_0020);
    settle();
    check(32'(ready_o), 32'h1);
    $display("test startup done");
    for (int c = 0; c < 2; c++) begin
      wr(6'(REG_CTRL + 6'h10 + 6'(c * 16)), 32'(tdly[c]));
      wr(6'(REG_CTRL + 6'h14 + 6'(c * 16)), 32'(shut[c]));
      wr(6'(REG_CTRL + 6'h18 + 6'(c * 16)), 32'(sdly[c]));
      wr(6'(REG_CTRL + 6'h1C + 6'(c * 16)), 32'(swid[c]));
    end
    wr(REG_OR_TIME, 32'h0000_0003);
    host(1'b0, 3);
    check(32'(ready_o), 32'h1);
    wr(REG_CTRL, 32'h0000_0400);
    settle();
    check(32'(ready_o), 32'h0);
    repeat (30) @(negedge clk_i);
    check(32'(ready_o), 32'h0);
    wr(REG_CTRL, 32'h0000_0040);
    wr(REG_CTRL, 32'h0000_0200);
    settle();
    check(32'(ready_o), 32'h1);
    $display("test command done");
    for (int m = 0; m < 3; m++) begin
      pol = m[0];
      job(m, m == 2);
    end
    wr(REG_JUDGE, 32'h0000_0000);
    host(1'b1, 5);
    check(32'(run_o), 32'h1);
    host(1'b1, 25);
    check(32'(run_o), 32'h0);
    rd(REG_STATUS, st);
    check(st, 32'h0000_0010);
    $display("test host reset done");
    wrap_up();
  end
endmodule // vtp_io_seq_tb

// ---- vtp_pkg.sv ----
package vtp_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned US_CYCLES       = CLK_MHZ;
  localparam int unsigned MEASURE_TRIGGER_INPUT_MIN_US     = 500;
  localparam int unsigned MEASURE_TRIGGER_INPUT_MIN_CYC    = MEASURE_TRIGGER_INPUT_MIN_US * CLK_MHZ;
  localparam int unsigned RESET_MIN_MS    = 10;
  localparam int unsigned RESET_MIN_CYC   = RESET_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned SHUT_MAX_US     = 2000;
  localparam int unsigned ENA_RESP_US     = 500;
  localparam int unsigned DLY_W           = 16;
  localparam int unsigned NUM_CAM         = 2;

  // ****************************************************************
  // Register map, byte offsets on the plain port.
  // ****************************************************************
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_STATUS   = 6'h04;
  localparam logic [5:0] REG_JUDGE    = 6'h08;
  localparam logic [5:0] REG_OR_TIME  = 6'h0C;
  localparam logic [5:0] REG_CAM_BASE = 6'h10;
  localparam logic [5:0] CAM_STRIDE   = 6'h10;
  localparam logic [5:0] CAM_TDLY     = 6'h00;
  localparam logic [5:0] CAM_SHUT     = 6'h04;
  localparam logic [5:0] CAM_SDLY     = 6'h08;
  localparam logic [5:0] CAM_SWID     = 6'h0C;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int unsigned CTRL_ENA_MODE_LO = 0;
  localparam int unsigned CTRL_OR_ONESHOT  = 2;
  localparam int unsigned CTRL_STB_POL     = 3;
  localparam int unsigned CTRL_BOOT_DONE   = 4;
  localparam int unsigned CTRL_INIT_DONE   = 5;
  localparam int unsigned CTRL_CMD_DONE    = 6;
  localparam int unsigned CTRL_MEAS_DONE   = 7;
  localparam int unsigned CTRL_DISP_DONE   = 8;
  localparam int unsigned CTRL_OUT_DONE    = 9;
  localparam int unsigned CTRL_CMD_ACCEPT  = 10;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // Ready timing patterns.
  typedef enum logic [1:0] {
    VTP_ENA_IMAGE = 2'h0,
    VTP_ENA_MEAS  = 2'h1,
    VTP_ENA_DISP  = 2'h2
  } vtp_ena_mode_t;

endpackage

// ---- vtp_us_tick.sv ----
`timescale 1ns/1ns
// One-microsecond tick generator shared by all delay counters.
module vtp_us_tick #(
  parameter int unsigned DIV = 100
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Tick out.
  output logic      tick_o
);
  logic [7:0] cnt_ff;

  // ****************************************************************
  // Divider.
  // ****************************************************************
  // Free-running divider; tick lasts one clock cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff == 8'(DIV - 1));
      cnt_ff <= (cnt_ff == 8'(DIV - 1)) ? 8'h00 : cnt_ff + 8'h01;
    end
  end
endmodule // vtp_us_tick
